/* logic/ebtc_map.svh */
// register offsets, field positions, reset values and counts of the timer
`ifndef EBTC_MAP_SVH
`define EBTC_MAP_SVH

`define EBTC_ADDR_W          3
`define EBTC_OFF_COUNT       3'h0
`define EBTC_OFF_OPTION      3'h1
`define EBTC_OFF_IRQ_STATUS  3'h2
`define EBTC_OFF_IRQ_CLEAR   3'h3
`define EBTC_OFF_IRQ_ENABLE  3'h4

`define EBTC_BIT_SRC_SEL     5
`define EBTC_BIT_EDGE_SEL    4
`define EBTC_BIT_BYPASS      3
`define EBTC_RATIO_MSB       2
`define EBTC_RATIO_LSB       0
`define EBTC_BIT_OVF         0

`define EBTC_OPTION_RESET    8'hFF
`define EBTC_COUNT_RESET     8'h00
`define EBTC_COUNT_MAX       8'hFF
`define EBTC_INHIBIT_CYCLES  2'h2

`endif

/* logic/ebtc_pkg.sv */
// types shared by the eight-bit timer/counter
package ebtc_pkg;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_Q1,
    PH_Q2,
    PH_Q3,
    PH_Q4
  } ebtc_phase_t;

  typedef logic [7:0] ebtc_byte_t;

endpackage

/* logic/ebtc_prescaler.sv */
// hidden prescale divider for the timer count path
`timescale 1ns/1ps
`default_nettype none

module ebtc_prescaler
  import ebtc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // control
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [2:0]       ratio,
  // divided output
  output logic                  outPulse
);

  logic [WIDTH-1:0] divCount;

  // ratio 000 divides by 2, each step doubles up to 111 at 256
  function automatic logic [WIDTH-1:0] ratioMask(input logic [2:0] r);
    logic [WIDTH:0] wide;
    // four-bit shift amount, or code 111 would wrap to a zero shift
    wide = ({{WIDTH{1'b0}}, 1'b1} << ({1'b0, r} + 4'h1)) - 1'b1;
    return wide[WIDTH-1:0];
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= '0;
    end else if (clear) begin
      divCount <= '0;
    end else if (tick) begin
      divCount <= divCount + 1'b1;
    end
  end

  // free-running count: the masked low bits are all ones once per period
  always_comb begin
    outPulse = tick && !clear &&
               ((divCount & ratioMask(ratio)) == ratioMask(ratio));
  end

endmodule // ebtc_prescaler

`default_nettype wire

/* logic/ebtc_timer.sv */
// eight-bit timer/counter with prescaler, overflow flag and register port
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ebtc_map.svh"

module ebtc_timer
  import ebtc_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,

  // register port
  input  wire logic [`EBTC_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWriteData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [7:0]             regReadData,

  // core state and external pin
  input  wire logic                   sleepMode,
  input  wire logic                   externalCountInput,

  // events
  output logic                        irqOut,
  output logic                        overflowGate
);

  // register state
  ebtc_byte_t  timerCount;
  ebtc_byte_t  optionReg;
  logic        overflowFlag;
  logic        overflowIrqEnable;

  // instruction cycle sequencing
  ebtc_phase_t phase;
  ebtc_phase_t next_phase;
  logic        isQ2;
  logic        isQ4;

  // count path
  logic        pinSync1;
  logic        pinSync2;
  logic        pinPrev;
  logic        pinEdge;
  logic        srcTick;
  logic        prescOut;
  logic        pathOut;
  logic        prescTick;
  logic        samplePoint;
  logic        edgePending;
  logic        incRequest;
  logic [1:0]  inhibitCount;
  logic        incNow;
  logic        wrapNow;

  // decoded accesses
  logic        writeCount;
  logic        writeOption;
  logic        writeClear;
  logic        writeEnable;

  // read port
  ebtc_byte_t  next_readData;

  // option fields
  logic        countSourceSelect;
  logic        sourceEdgeSelect;
  logic        prescalerBypass;
  logic [2:0]  prescaleRatio;

  function automatic logic isWriteTo(
    input logic [`EBTC_ADDR_W-1:0] a,
    input logic [`EBTC_ADDR_W-1:0] off,
    input logic                    w
  );
    return w && (a == off);
  endfunction

  assign writeCount  = isWriteTo(regAddr, `EBTC_OFF_COUNT, regWrite);
  assign writeOption = isWriteTo(regAddr, `EBTC_OFF_OPTION, regWrite);
  assign writeClear  = isWriteTo(regAddr, `EBTC_OFF_IRQ_CLEAR, regWrite);
  assign writeEnable = isWriteTo(regAddr, `EBTC_OFF_IRQ_ENABLE, regWrite);

  assign countSourceSelect = optionReg[`EBTC_BIT_SRC_SEL];
  assign sourceEdgeSelect  = optionReg[`EBTC_BIT_EDGE_SEL];
  assign prescalerBypass   = optionReg[`EBTC_BIT_BYPASS];
  assign prescaleRatio     = optionReg[`EBTC_RATIO_MSB:`EBTC_RATIO_LSB];

  assign isQ2 = (phase == PH_Q2);
  assign isQ4 = (phase == PH_Q4);
  assign samplePoint = isQ2 || isQ4;

  // ---------------------------------------------------------------
  // instruction cycle phases; the core clock stops in sleep
  // ---------------------------------------------------------------
  always_comb begin
    case (phase)
      PH_Q1:   next_phase = PH_Q2;
      PH_Q2:   next_phase = PH_Q3;
      PH_Q3:   next_phase = PH_Q4;
      PH_Q4:   next_phase = PH_Q1;
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= PH_Q1;
    end else if (!sleepMode) begin
      phase <= next_phase;
    end
  end

  // ---------------------------------------------------------------
  // external pin: two-stage synchroniser, then edge history
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
    end else begin
      pinSync1 <= externalCountInput;
      pinSync2 <= pinSync1;
    end
  end

  // history resets to the pin's idle low level, so a quiet pin gives
  // no false edge right after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinSync2;
    end
  end

  // edge select 1 counts high-to-low, 0 counts low-to-high
  always_comb begin
    if (sourceEdgeSelect) begin
      pinEdge = pinPrev && !pinSync2;
    end else begin
      pinEdge = !pinPrev && pinSync2;
    end
  end

  // source: one tick per instruction cycle, or a selected pin edge
  always_comb begin
    if (sleepMode) begin
      srcTick = 1'b0;
    end else if (countSourceSelect) begin
      srcTick = pinEdge;
    end else begin
      srcTick = isQ4;
    end
  end

  // the divider only sees ticks while it sits in the count path
  assign prescTick = srcTick && !prescalerBypass;

  ebtc_prescaler #(
    .WIDTH    (PRESCALE_WIDTH)
  ) u_prescaler (
    .clk      (clk),
    .resetn   (resetn),
    .clear    (writeCount),
    .tick     (prescTick),
    .ratio    (prescaleRatio),
    .outPulse (prescOut)
  );

  // bypass set gives 1:1 and the ratio field has no effect
  assign pathOut = prescalerBypass ? srcTick : prescOut;

  // ---------------------------------------------------------------
  // sampling of the path output at Q2 and Q4
  // ---------------------------------------------------------------
  // a pulse between sample points is held so it is never missed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgePending <= 1'b0;
    end else if (writeCount) begin
      edgePending <= 1'b0;
    end else if (sleepMode) begin
      // sleep freezes a caught pulse instead of dropping it
      edgePending <= edgePending;
    end else if (samplePoint) begin
      edgePending <= 1'b0;
    end else if (pathOut) begin
      edgePending <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      incRequest <= 1'b0;
    end else if (writeCount) begin
      incRequest <= 1'b0;
    end else if (sleepMode) begin
      incRequest <= incRequest;
    end else if (isQ2) begin
      incRequest <= incRequest || edgePending || pathOut;
    end else if (isQ4) begin
      // the Q2 capture is spent at this Q4, so start afresh
      incRequest <= edgePending || pathOut;
    end
  end

  // ---------------------------------------------------------------
  // write inhibit, counted in instruction cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inhibitCount <= 2'h0;
    end else if (writeCount) begin
      inhibitCount <= `EBTC_INHIBIT_CYCLES;
    end else if (!sleepMode && isQ4 && inhibitCount != 2'h0) begin
      inhibitCount <= inhibitCount - 2'h1;
    end
  end

  // the count moves only at the end of Q4, one step per cycle at most
  assign incNow  = isQ4 && incRequest && !sleepMode &&
                   !writeCount && (inhibitCount == 2'h0);
  assign wrapNow = incNow && (timerCount == `EBTC_COUNT_MAX);

  // ---------------------------------------------------------------
  // count register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerCount <= `EBTC_COUNT_RESET;
    end else if (writeCount) begin
      timerCount <= regWriteData;
    end else if (incNow) begin
      timerCount <= timerCount + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // option register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      optionReg <= `EBTC_OPTION_RESET;
    end else if (writeOption) begin
      optionReg <= regWriteData;
    end
  end

  // ---------------------------------------------------------------
  // overflow flag and interrupt
  // ---------------------------------------------------------------
  // a wrap in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflowFlag <= 1'b0;
    end else if (wrapNow) begin
      overflowFlag <= 1'b1;
    end else if (writeClear && regWriteData[`EBTC_BIT_OVF]) begin
      overflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflowIrqEnable <= 1'b0;
    end else if (writeEnable) begin
      // reads back, so software can save and restore the mask
      overflowIrqEnable <= regWriteData[`EBTC_BIT_OVF];
    end
  end

  // follows the flag one cycle later; it cannot wake from sleep
  // since no wrap happens there
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= overflowFlag && overflowIrqEnable;
    end
  end

  // one-cycle pulse for the gate of the 16-bit timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflowGate <= 1'b0;
    end else begin
      overflowGate <= wrapNow;
    end
  end

  // ---------------------------------------------------------------
  // read port: data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  // the prescaler count has no address, so software never sees it
  always_comb begin
    next_readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        `EBTC_OFF_COUNT:      next_readData = timerCount;
        `EBTC_OFF_OPTION:     next_readData = optionReg;
        `EBTC_OFF_IRQ_STATUS: next_readData = {7'h00, overflowFlag};
        `EBTC_OFF_IRQ_ENABLE: next_readData = {7'h00, overflowIrqEnable};
        default:              next_readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

endmodule // ebtc_timer

`default_nettype wire

/* dv/ebtc_pin_source.sv */
// count pin source: toggles the external pin a set number of times
`timescale 1ns/1ps
`default_nettype none

module ebtc_pin_source (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // command
  input  wire logic       start,
  input  wire logic [3:0] edgeCount,
  // pin
  output logic            pin,
  output logic            busy
);
  logic [3:0] left;
  logic [3:0] gap;

  // sixteen clocks between edges so the synchroniser never merges two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin  <= 1'b0;
      left <= 4'h0;
      gap  <= 4'h0;
    end else if (start) begin
      left <= edgeCount;
      gap  <= 4'hF;
    end else if (left != 4'h0) begin
      gap <= gap - 4'h1;
      if (gap == 4'h0) begin
        pin  <= ~pin;
        left <= left - 4'h1;
      end
    end
  end

  assign busy = (left != 4'h0);
endmodule // ebtc_pin_source
`default_nettype wire

/* dv/ebtc_timer_checker.sv */
// assertions on the timer's register port and event outputs
`timescale 1ns/1ps
`default_nettype none
`include "ebtc_map.svh"

module ebtc_timer_checker
  import ebtc_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // register port
  input wire logic [`EBTC_ADDR_W-1:0] regAddr,
  input wire logic [7:0]              regWriteData,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [7:0]              regReadData,
  // core, pin and events
  input wire logic                    sleepMode,
  input wire logic                    externalCountInput,
  input wire logic                    irqOut,
  input wire logic                    overflowGate
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!resetn);

  // any write that may legally drop the irq, unmapped ones included
  logic irqWrite;
  assign irqWrite = regWrite && regAddr >= `EBTC_OFF_IRQ_CLEAR;

  sequence s_cnt_wr;
    regWrite && regAddr == `EBTC_OFF_COUNT;
  endsequence
  sequence s_cnt_rd;
    regRead && !regWrite && regAddr == `EBTC_OFF_COUNT;
  endsequence

  a_read_idle: assert property (
    !regRead |=> regReadData == 8'h00) else $error("read data not idle");
  a_count_load: assert property (
    s_cnt_wr ##1 !regWrite ##1 s_cnt_rd
      |=> regReadData == $past(regWriteData, 3))
    else $error("count write not loaded");
  a_write_hold: assert property (
    s_cnt_wr ##1 (!regWrite)[*5] ##1 s_cnt_rd
      |=> regReadData == $past(regWriteData, 7))
    else $error("count moved while blocked");
  a_irq_hold: assert property (
    irqOut && !irqWrite && !$past(irqWrite) |=> irqOut)
    else $error("irq dropped without clear");
  a_irq_clear: assert property (
    regWrite && regAddr == `EBTC_OFF_IRQ_CLEAR && regWriteData[0]
      ##1 (!overflowGate)[*3] |-> !irqOut) else $error("irq not cleared");
  a_irq_mask: assert property (
    regWrite && regAddr == `EBTC_OFF_IRQ_ENABLE && !regWriteData[0]
      |-> ##2 !irqOut) else $error("masked irq raised");
  a_gate_pulse: assert property (
    overflowGate |=> !overflowGate) else $error("gate pulse too long");
  a_gate_flag: assert property (
    overflowGate ##1 (regRead && regAddr == `EBTC_OFF_IRQ_STATUS)
      |=> regReadData[0]) else $error("wrap left flag clear");
  a_sleep_quiet: assert property (
    sleepMode[*6] |-> !overflowGate) else $error("wrap during sleep");
endmodule // ebtc_timer_checker

bind ebtc_timer ebtc_timer_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) chk (
  .clk(clk), .resetn(resetn), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .sleepMode(sleepMode),
  .externalCountInput(externalCountInput), .irqOut(irqOut),
  .overflowGate(overflowGate)
);
`default_nettype wire

/* dv/test_ebtc_timer.sv */
// self-checking bench for the eight-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "ebtc_map.svh"

module test_ebtc_timer
  import ebtc_pkg::*;
;
  logic                    clk, resetn, regWrite, regRead, sleepMode;
  logic                    irqOut, overflowGate, pin, pinStart, pinBusy;
  logic [`EBTC_ADDR_W-1:0] regAddr;
  logic [3:0]              pinEdges;
  ebtc_byte_t              regWriteData, regReadData, rv, a;
  int                      errCount = 0;
  int                      cmpCount = 0;

  ebtc_timer dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .sleepMode(sleepMode),
    .externalCountInput(pin), .irqOut(irqOut), .overflowGate(overflowGate)
  );
  ebtc_pin_source source (
    .clk(clk), .resetn(resetn), .start(pinStart), .edgeCount(pinEdges),
    .pin(pin), .busy(pinBusy)
  );

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input ebtc_byte_t seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [`EBTC_ADDR_W-1:0] ad, input ebtc_byte_t d);
    regWrite <= 1'b1;
    regAddr <= ad;
    regWriteData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    // one idle cycle, so two writes never touch the strobe in one step
    @(posedge clk);
  endtask
  task automatic rd(input logic [`EBTC_ADDR_W-1:0] ad, output ebtc_byte_t d);
    regRead <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regReadData;
    @(posedge clk);
  endtask
  task automatic waitFor(input logic onGate);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (onGate ? overflowGate === 1'b1 : pinBusy === 1'b0) break;
    end
    if (i == 300) begin
      errCount++;
      $display("unexpected wait: expected under 300 seen 300");
      conclude();
    end
    @(posedge clk);
  endtask
  task automatic irqIs(input logic e);
    @(negedge clk);
    chk("irq", {7'h00, irqOut}, {7'h00, e});
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(`EBTC_OFF_OPTION, rv);
    chk("option", rv, 8'hFF);
    rd(`EBTC_OFF_COUNT, rv);
    chk("count", rv, 8'h00);
    rd(3'h5, rv);
    chk("unmapped", rv, 8'h00);
  endtask
  // ratio field set but bypassed: must still step once per cycle
  task automatic t_timer();
    wr(`EBTC_OFF_OPTION, 8'h0F);
    wr(`EBTC_OFF_COUNT, 8'h10);
    rd(`EBTC_OFF_COUNT, rv);
    chk("loaded", rv, 8'h10);
    cyc(2);
    rd(`EBTC_OFF_COUNT, rv);
    chk("blocked", rv, 8'h10);
    cyc(26);
    rd(`EBTC_OFF_COUNT, rv);
    chk("running", rv, 8'h16);
  endtask
  // window of two prescale periods gives exactly two steps at any phase
  task automatic t_prescale();
    for (int n = 0; n < 8; n++) begin
      wr(`EBTC_OFF_OPTION, 8'(n));
      wr(`EBTC_OFF_COUNT, 8'h00);
      cyc(12);
      rd(`EBTC_OFF_COUNT, a);
      cyc((8 << (n + 1)) - 2);
      rd(`EBTC_OFF_COUNT, rv);
      chk("ratio", rv - a, 8'h02);
    end
    cyc(600);
    wr(`EBTC_OFF_COUNT, 8'h00);
    cyc(896);
    rd(`EBTC_OFF_COUNT, rv);
    chk("cleared", rv, 8'h00);
    cyc(200);
    rd(`EBTC_OFF_COUNT, rv);
    chk("restart", rv, 8'h01);
  endtask
  task automatic t_counter(input ebtc_byte_t opt);
    wr(`EBTC_OFF_OPTION, opt);
    wr(`EBTC_OFF_COUNT, 8'h00);
    cyc(12);
    pinEdges <= 4'h5;
    pinStart <= 1'b1;
    @(posedge clk);
    pinStart <= 1'b0;
    waitFor(1'b0);
    cyc(24);
    rd(`EBTC_OFF_COUNT, rv);
    chk("edges", rv, 8'h03);
  endtask
  task automatic t_overflow(input logic en);
    wr(`EBTC_OFF_OPTION, 8'h08);
    wr(`EBTC_OFF_IRQ_ENABLE, {7'h00, en});
    rd(`EBTC_OFF_IRQ_ENABLE, rv);
    chk("enable", rv, {7'h00, en});
    wr(`EBTC_OFF_COUNT, 8'hFD);
    waitFor(1'b1);
    rd(`EBTC_OFF_IRQ_STATUS, rv);
    chk("flag", rv, 8'h01);
    cyc(100);
    irqIs(en);
    rd(`EBTC_OFF_IRQ_STATUS, rv);
    chk("flag kept", rv, 8'h01);
    wr(`EBTC_OFF_IRQ_CLEAR, 8'h01);
    cyc(3);
    irqIs(1'b0);
    rd(`EBTC_OFF_IRQ_STATUS, rv);
    chk("flag clear", rv, 8'h00);
  endtask
  task automatic t_sleep();
    sleepMode <= 1'b1;
    cyc(6);
    rd(`EBTC_OFF_COUNT, a);
    cyc(40);
    rd(`EBTC_OFF_COUNT, rv);
    chk("asleep", rv, a);
    sleepMode <= 1'b0;
    cyc(4);
    rd(`EBTC_OFF_COUNT, a);
    cyc(38);
    rd(`EBTC_OFF_COUNT, rv);
    chk("awake", rv - a, 8'h0A);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    {regWrite, regRead, sleepMode, pinStart} = 4'h0;
    regAddr = 3'h0;
    regWriteData = 8'h00;
    pinEdges = 4'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_prescale();
    t_counter(8'h28);
    t_counter(8'h38);
    t_overflow(1'b1);
    t_overflow(1'b0);
    t_sleep();
    conclude();
  end
endmodule // test_ebtc_timer
`default_nettype wire
